// [ifm_pkg.sv]
`default_nettype none
package ifm_pkg;
	localparam int unsigned fifo_depth = 8;
	localparam int unsigned cnt_w = 4;
	localparam logic [7:0] empty_read_value = 8'hff;
	// register word addresses
	localparam logic [7:0] addr_ctrl = 8'h00;
	localparam logic [7:0] addr_status = 8'h04;
	localparam logic [7:0] addr_flags = 8'h08;
	localparam logic [7:0] addr_txctrl = 8'h0c;
	localparam logic [7:0] addr_rxctrl = 8'h10;
	localparam logic [7:0] addr_fifo = 8'h14;
	localparam logic [7:0] addr_mstr = 8'h18;
	localparam logic [7:0] addr_dma = 8'h1c;
	// ctrl fields
	localparam int unsigned ctrl_en = 0;
	localparam int unsigned ctrl_mst = 1;
	localparam int unsigned ctrl_irxm = 2;
	localparam int unsigned ctrl_ack = 3;
	// flags fields (write one to clear)
	localparam int unsigned flag_irxm = 0;
	localparam int unsigned flag_txlo = 1;
	// txctrl / rxctrl fields
	localparam int unsigned fld_flush = 0;
	localparam int unsigned fld_preload = 1;
	localparam int unsigned fld_th_lsb = 4;
	// master control fields
	localparam int unsigned mc_start = 0;
	localparam int unsigned mc_restart = 1;
	localparam int unsigned mc_stop = 2;
	// dma fields
	localparam int unsigned dma_tx = 0;
	localparam int unsigned dma_rx = 1;
	// bus times
	localparam int unsigned clk_period_ps = 4000;
	localparam int unsigned scl_low_ns = 1300;
	localparam int unsigned scl_low_cycles = (scl_low_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
	localparam int unsigned bits_per_byte = 8;
	typedef enum logic [4:0] {
		ifm_idle = 5'h01,
		ifm_start = 5'h02,
		ifm_xfer = 5'h04,
		ifm_restart = 5'h08,
		ifm_stop = 5'h10
	} ifm_mstate_t;
endpackage
`default_nettype wire

// [ifm_mem.sv]
`default_nettype none
module ifm_mem #(
	parameter int unsigned depth = 8,
	parameter int unsigned aw = 3
) (
	input wire logic ref_clk,
	input wire logic we,
	input wire logic [aw-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [aw-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [depth];
	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
	always_ff @(posedge ref_clk) begin
		rdata <= mem[raddr];
	end
endmodule // ifm_mem
`default_nettype wire

// [ifm_fifo.sv]
`default_nettype none
// 8-bit fifo; read data follow one cycle after the pop
module ifm_fifo #(
	parameter int unsigned depth = 8,
	parameter int unsigned cw = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic push,
	input wire logic [7:0] wdata,
	input wire logic pop,
	output logic [7:0] rdata,
	output logic [cw-1:0] count
);
	logic [cw-2:0] wp;
	logic [cw-2:0] rp;
	logic do_push;
	logic do_pop;
	assign do_push = push && (count < cw'(depth));
	assign do_pop = pop && (count != '0);
	always_ff @(posedge ref_clk) begin
		if (!rst_n || flush) begin
			wp <= '0;
			rp <= '0;
			count <= '0;
		end else begin
			if (do_push) begin
				wp <= wp + 1'b1;
			end
			if (do_pop) begin
				rp <= rp + 1'b1;
			end
			count <= count + cw'(do_push) - cw'(do_pop);
		end
	end
	ifm_mem #(.depth(depth), .aw(cw - 1)) u_mem (
		.ref_clk(ref_clk),
		.we(do_push),
		.waddr(wp),
		.wdata(wdata),
		.raddr(rp),
		.rdata(rdata)
	);
endmodule // ifm_fifo
`default_nettype wire

// [ifm_ctrl.sv]
`default_nettype none
module ifm_ctrl #(
	parameter int unsigned depth = ifm_pkg::fifo_depth
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// bus pins
	input wire logic scl_in,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_oe,
	// events from the bus engine
	input wire logic addr_match,
	input wire logic gc_match,
	input wire logic slv_tx_nack,
	input wire logic err_event,
	input wire logic byte_done,
	input wire logic [7:0] rx_byte,
	input wire logic rx_is_data,
	input wire logic tx_pop,
	input wire logic bus_busy,
	input wire logic xfer_done,
	input wire logic stop_seen,
	// to the bus engine
	output logic [7:0] tx_byte,
	output logic [ifm_pkg::cnt_w-1:0] tx_count,
	output logic gen_start,
	output logic gen_restart,
	output logic gen_stop,
	output logic tx_dma_req,
	output logic rx_dma_req
);
	logic scl_m;
	logic scl_s;
	logic scl_d;
	logic sda_m;
	logic sda_s;
	logic scl_fall;
	logic [3:0] ctrl;
	logic irxm_flag;
	logic txlo_flag;
	logic tx_preload;
	logic [ifm_pkg::cnt_w-1:0] tx_th;
	logic [ifm_pkg::cnt_w-1:0] rx_th;
	logic [1:0] dma_en;
	logic [2:0] mc;
	logic [3:0] fall_cnt;
	logic [7:0] shift;
	logic stall;
	logic ack_drive;
	logic [15:0] low_cnt;
	logic [ifm_pkg::cnt_w-1:0] rx_count;
	logic [7:0] rx_q;
	logic rd_fifo_d;
	logic rd_fifo_empty_d;
	logic rd_irxm_d;
	logic [31:0] reg_rdata;
	logic tx_push;
	logic tx_flush;
	logic rx_flush;
	logic rx_push;
	logic rx_pop;
	logic lock_event;
	logic flag_clear_irxm;
	logic flag_clear_txlo;
	logic wr_fifo;
	logic rd_fifo;
	ifm_pkg::ifm_mstate_t mstate;
	ifm_pkg::ifm_mstate_t next_mstate;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] want, input logic s);
		return s && (a == want);
	endfunction

	// pins are asynchronous to ref_clk; only the second stage and the delayed scl copy behind it are read
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			scl_d <= 1'b1;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			sda_m <= sda_in;
			sda_s <= sda_m;
			scl_d <= scl_s;
		end
	end
	assign scl_fall = scl_d && !scl_s;

	assign wr_fifo = hit(addr, ifm_pkg::addr_fifo, wr);
	assign rd_fifo = hit(addr, ifm_pkg::addr_fifo, rd);
	assign flag_clear_irxm = hit(addr, ifm_pkg::addr_flags, wr) && wdata[ifm_pkg::flag_irxm];
	assign flag_clear_txlo = hit(addr, ifm_pkg::addr_flags, wr) && wdata[ifm_pkg::flag_txlo];

	// configuration registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl <= '0;
			tx_preload <= 1'b0;
			tx_th <= '0;
			rx_th <= ifm_pkg::cnt_w'(1);
			dma_en <= '0;
		end else begin
			if (hit(addr, ifm_pkg::addr_ctrl, wr)) begin
				ctrl <= wdata[3:0];
			end
			if (hit(addr, ifm_pkg::addr_txctrl, wr)) begin
				tx_preload <= wdata[ifm_pkg::fld_preload];
				tx_th <= wdata[ifm_pkg::fld_th_lsb +: ifm_pkg::cnt_w];
			end
			if (hit(addr, ifm_pkg::addr_rxctrl, wr)) begin
				rx_th <= wdata[ifm_pkg::fld_th_lsb +: ifm_pkg::cnt_w];
			end
			if (hit(addr, ifm_pkg::addr_dma, wr)) begin
				dma_en <= wdata[1:0];
			end
		end
	end

	// flush and lockout
	assign lock_event = ((addr_match || gc_match) && !tx_preload) || slv_tx_nack || err_event
		|| stop_seen;
	assign tx_flush = !ctrl[ifm_pkg::ctrl_en] || lock_event
		|| (hit(addr, ifm_pkg::addr_txctrl, wr) && wdata[ifm_pkg::fld_flush]);
	assign rx_flush = !ctrl[ifm_pkg::ctrl_en]
		|| (hit(addr, ifm_pkg::addr_rxctrl, wr) && wdata[ifm_pkg::fld_flush]);
	assign tx_push = wr_fifo && !txlo_flag;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			txlo_flag <= 1'b0;
		end else if (lock_event) begin
			txlo_flag <= 1'b1;
		end else if (flag_clear_txlo) begin
			txlo_flag <= 1'b0;
		end
	end

	ifm_fifo #(.depth(depth), .cw(ifm_pkg::cnt_w)) u_tx (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.flush(tx_flush),
		.push(tx_push),
		.wdata(wdata[7:0]),
		.pop(tx_pop),
		.rdata(tx_byte),
		.count(tx_count)
	);

	// interactive receive: bytes go to the shifter, not the fifo
	assign rx_push = byte_done && !ctrl[ifm_pkg::ctrl_irxm];
	assign rx_pop = rd_fifo && !ctrl[ifm_pkg::ctrl_irxm];

	ifm_fifo #(.depth(depth), .cw(ifm_pkg::cnt_w)) u_rx (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.flush(rx_flush),
		.push(rx_push),
		.wdata(rx_byte),
		.pop(rx_pop),
		.rdata(rx_q),
		.count(rx_count)
	);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fall_cnt <= '0;
			shift <= '0;
		end else if (byte_done || !ctrl[ifm_pkg::ctrl_en]) begin
			fall_cnt <= '0;
			shift <= rx_byte;
		end else if (scl_fall && !stall) begin
			fall_cnt <= fall_cnt + 4'h1;
		end
	end

	// the irxm flag sets the scl hold (stall) one cycle later; set wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irxm_flag <= 1'b0;
		end else if (ctrl[ifm_pkg::ctrl_irxm] && rx_is_data && scl_fall
				&& fall_cnt == 4'(ifm_pkg::bits_per_byte - 1)) begin
			irxm_flag <= 1'b1;
		end else if (flag_clear_irxm) begin
			irxm_flag <= 1'b0;
		end
	end

	// after the release request scl stays low until it has been seen low for the low time, counted from the start of the stall
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			low_cnt <= '0;
			stall <= 1'b0;
			ack_drive <= 1'b0;
		end else begin
			if (irxm_flag) begin
				stall <= 1'b1;
			end else if (stall && low_cnt >= 16'(ifm_pkg::scl_low_cycles)) begin
				stall <= 1'b0;
			end
			if (stall && !scl_s) begin
				low_cnt <= (low_cnt == 16'hffff) ? low_cnt : low_cnt + 16'h1;
			end else begin
				low_cnt <= '0;
			end
			if (flag_clear_irxm && irxm_flag) begin
				ack_drive <= !ctrl[ifm_pkg::ctrl_ack];
			end else if (scl_fall && !stall) begin
				ack_drive <= 1'b0;
			end
		end
	end
	assign scl_oe = stall;
	assign sda_oe = ack_drive && !stall;

	// master condition control
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mstate <= ifm_pkg::ifm_idle;
		end else begin
			mstate <= next_mstate;
		end
	end
	always_comb begin
		next_mstate = mstate;
		case (mstate)
			ifm_pkg::ifm_idle: begin
				if (mc[ifm_pkg::mc_start] && !bus_busy) begin
					next_mstate = ifm_pkg::ifm_start;
				end
			end
			ifm_pkg::ifm_start: begin
				next_mstate = ifm_pkg::ifm_xfer;
			end
			ifm_pkg::ifm_xfer: begin
				if (xfer_done && mc[ifm_pkg::mc_restart]) begin
					next_mstate = ifm_pkg::ifm_restart;
				end else if (xfer_done && mc[ifm_pkg::mc_stop]) begin
					next_mstate = ifm_pkg::ifm_stop;
				end
			end
			ifm_pkg::ifm_restart: begin
				next_mstate = ifm_pkg::ifm_xfer;
			end
			ifm_pkg::ifm_stop: begin
				next_mstate = ifm_pkg::ifm_idle;
			end
			default: begin
				next_mstate = ifm_pkg::ifm_idle;
			end
		endcase
		if (!ctrl[ifm_pkg::ctrl_mst]) begin
			next_mstate = ifm_pkg::ifm_idle;
		end
	end
	assign gen_start = (mstate == ifm_pkg::ifm_start);
	assign gen_restart = (mstate == ifm_pkg::ifm_restart);
	assign gen_stop = (mstate == ifm_pkg::ifm_stop);

	always_ff @(posedge ref_clk) begin
		if (!rst_n || !ctrl[ifm_pkg::ctrl_mst]) begin
			mc <= '0;
		end else if (hit(addr, ifm_pkg::addr_mstr, wr)) begin
			mc <= mc | wdata[2:0];
		end else begin
			if (gen_restart) begin
				mc[ifm_pkg::mc_restart] <= 1'b0;
				mc[ifm_pkg::mc_stop] <= 1'b0;
			end else if (stop_seen) begin
				mc[ifm_pkg::mc_restart] <= 1'b0;
			end
			if (gen_stop) begin
				mc <= '0;
			end
		end
	end

	assign tx_dma_req = dma_en[ifm_pkg::dma_tx] && (tx_count <= tx_th);
	assign rx_dma_req = dma_en[ifm_pkg::dma_rx] && (rx_count >= rx_th) && (rx_count != '0);

	// read data, one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_fifo_d <= 1'b0;
			rd_fifo_empty_d <= 1'b0;
			rd_irxm_d <= 1'b0;
		end else begin
			rd_fifo_d <= rd_fifo;
			rd_fifo_empty_d <= (rx_count == '0);
			rd_irxm_d <= ctrl[ifm_pkg::ctrl_irxm];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (rd) begin
			case (addr)
				ifm_pkg::addr_ctrl: reg_rdata <= {28'h0, ctrl};
				ifm_pkg::addr_status: reg_rdata <= {21'h0, sda_s, stall, mstate, rx_count};
				ifm_pkg::addr_flags: reg_rdata <= {30'h0, txlo_flag, irxm_flag};
				ifm_pkg::addr_txctrl: reg_rdata <= {20'h0, tx_count, tx_th, 2'h0, tx_preload, 1'b0};
				ifm_pkg::addr_rxctrl: reg_rdata <= {20'h0, rx_count, rx_th, 4'h0};
				ifm_pkg::addr_mstr: reg_rdata <= {29'h0, mc};
				ifm_pkg::addr_dma: reg_rdata <= {30'h0, dma_en};
				default: reg_rdata <= '0;
			endcase
		end
	end
	// fifo read data leave the memory one cycle late, so the data port is muxed after the register
	logic [31:0] port_data;
	always_comb begin
		if (rd_irxm_d) begin
			port_data = {24'h0, shift};
		end else if (rd_fifo_empty_d) begin
			port_data = {24'h0, ifm_pkg::empty_read_value};
		end else begin
			port_data = {24'h0, rx_q};
		end
	end
	// reg_rdata is a flop and port_data a mux of flops; the select is the registered strobe
	assign rdata = rd_fifo_d ? port_data : reg_rdata;

	a_lock_blocks_push: assert property (@(posedge ref_clk) disable iff (!rst_n)
		txlo_flag && wr_fifo && !tx_flush && !tx_pop |=> tx_count == $past(tx_count)) else $error("write taken under lockout");
	a_master_off_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!ctrl[ifm_pkg::ctrl_mst] |=> mc == '0) else $error("requests kept with master off");
	a_start_bus_free: assert property (@(posedge ref_clk) disable iff (!rst_n)
		gen_start |-> $past(!bus_busy)) else $error("start on busy bus");
	a_tx_dma_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tx_dma_req |-> dma_en[ifm_pkg::dma_tx] && tx_count <= tx_th) else $error("tx dma request wrong");
	a_rx_dma_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
		dma_en[ifm_pkg::dma_rx] && rx_count >= rx_th && rx_count != '0 |-> rx_dma_req) else $error("rx dma missing");
	a_lock_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lock_event |=> txlo_flag && tx_count == '0) else $error("lock event missed");
	a_disable_flush: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!ctrl[ifm_pkg::ctrl_en] |=> tx_count == '0 && rx_count == '0) else $error("fifo kept while off");
	a_stall_holds_scl: assert property (@(posedge ref_clk) disable iff (!rst_n)
		irxm_flag |=> scl_oe) else $error("scl not held");
	a_restart_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
		gen_restart && ctrl[ifm_pkg::ctrl_mst] && !hit(addr, ifm_pkg::addr_mstr, wr)
		|=> !mc[ifm_pkg::mc_restart] && !mc[ifm_pkg::mc_stop]) else $error("restart bits kept");
	a_fifo_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tx_count <= ifm_pkg::cnt_w'(depth) && rx_count <= ifm_pkg::cnt_w'(depth)) else $error("fifo over depth");
endmodule // ifm_ctrl
`default_nettype wire

// [ifm_bus_peer.sv]
`default_nettype none
// far-side i2c party; both lines are open drain with pull-ups, so a released line reads high
module ifm_bus_peer (
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic scl_in,
	output logic sda_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic scl_hi = 1'b1;
	logic sda_hi = 1'b1;
	assign scl_in = scl_hi & ~scl_oe;
	assign sda_in = sda_hi & ~sda_oe;
	// eight data bits at a 48 ns bit period; scl starts high so only the eight bit-end falls are seen
	// limitation: the first sda change happens with scl high; no condition decoding sits behind this pin
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sda_hi = b[i];
			#12;
			scl_hi = 1'b1;
			#24;
			scl_hi = 1'b0;
			#12;
		end
		sda_hi = 1'b1;
	endtask
	// clock stands still between frames
	task automatic idle();
		scl_hi = 1'b1;
		sda_hi = 1'b1;
	endtask
endmodule // ifm_bus_peer
`default_nettype wire

// [tb_i2c_fifo_irxm_master_control.sv]
`default_nettype none
module tb_i2c_fifo_irxm_master_control;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, rx_is_data = 1, bus_busy = 0;
	logic [7:0] addr = 0, rx_byte = 0, ev = 0, b;
	logic [31:0] wdata = 0, rdata, d;
	logic scl_in, sda_in, scl_oe, sda_oe, gen_start, gen_restart, gen_stop, tx_dma_req, rx_dma_req;
	logic [7:0] tx_byte;
	logic [3:0] tx_count;
	int fails = 0, checked = 0, ns = 0, nr = 0, np = 0, n, seed = 32'h955f, tth = 0, rth = 1;
	bit lock = 0, dma = 0;
	int txq[$], rxq[$];
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (gen_start === 1'b1) ns++;
		if (gen_restart === 1'b1) nr++;
		if (gen_stop === 1'b1) np++;
	end
	ifm_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr_s), .rd(rd_s),
		.rdata(rdata), .scl_in(scl_in), .scl_oe(scl_oe), .sda_in(sda_in), .sda_oe(sda_oe),
		.addr_match(ev[0]), .gc_match(ev[1]), .slv_tx_nack(ev[2]), .err_event(ev[3]), .byte_done(ev[4]),
		.rx_byte(rx_byte), .rx_is_data(rx_is_data), .tx_pop(ev[5]), .bus_busy(bus_busy), .xfer_done(ev[6]),
		.stop_seen(ev[7]), .tx_byte(tx_byte), .tx_count(tx_count), .gen_start(gen_start),
		.gen_restart(gen_restart), .gen_stop(gen_stop), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
	ifm_bus_peer peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));
	task automatic end_of_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1;
		@(posedge ref_clk);
		wr_s <= 0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		rd_s <= 1;
		@(posedge ref_clk);
		rd_s <= 0;
		#1 v = rdata;
	endtask
	task automatic pulse(input int k, input logic [7:0] v);
		@(posedge ref_clk);
		ev <= 8'h01 << k;
		rx_byte <= v;
		@(posedge ref_clk);
		ev <= 0;
		#1;
	endtask
	// dma requests follow the counts combinationally; still give them one edge to settle
	task automatic chk_lvl();
		@(posedge ref_clk);
		#1;
		chk("tx_count", txq.size(), {28'h0, tx_count});
		chk("tx_dma_req", dma && txq.size() <= tth, {31'h0, tx_dma_req});
		chk("rx_dma_req", dma && rxq.size() >= rth, {31'h0, rx_dma_req});
	endtask
	task automatic push_tx(input logic [31:0] v);
		wr(ifm_pkg::addr_fifo, v);
		if (!lock && txq.size() < 8) txq.push_back(v[7:0]);
	endtask
	task automatic push_rx(input logic [7:0] v);
		pulse(4, v);
		if (rxq.size() < 8) rxq.push_back(v);
	endtask
	task automatic pop_rx();
		rd(ifm_pkg::addr_fifo, d);
		chk("rx_data", rxq.size() ? rxq.pop_front() : 32'hff, d);
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1;
		chk_lvl();
		wr(ifm_pkg::addr_ctrl, 32'h3);
		for (int i = 0; i < 10; i++) push_tx($random(seed));
		chk_lvl();
		for (int i = 0; i < 8; i++) begin
			pulse(5, 0);
			chk("tx_byte", txq.pop_front(), {24'h0, tx_byte});
		end
		for (int i = 0; i < 9; i++) push_rx($random(seed));
		for (int i = 0; i < 9; i++) pop_rx();
		dma = 1;
		tth = 2;
		rth = 3;
		wr(ifm_pkg::addr_txctrl, 32'h20);
		wr(ifm_pkg::addr_rxctrl, 32'h30);
		wr(ifm_pkg::addr_dma, 32'h3);
		for (int i = 0; i < 6; i++) begin
			chk_lvl();
			push_tx($random(seed));
			push_rx($random(seed));
		end
		wr(ifm_pkg::addr_txctrl, 32'h21);
		txq.delete();
		chk_lvl();
		pop_rx();
		wr(ifm_pkg::addr_rxctrl, 32'h31);
		rxq.delete();
		chk_lvl();
		pop_rx();
		push_tx($random(seed));
		push_rx($random(seed));
		wr(ifm_pkg::addr_ctrl, 32'h0);
		txq.delete();
		rxq.delete();
		wr(ifm_pkg::addr_ctrl, 32'h3);
		chk_lvl();
		pop_rx();
		for (int k = 0; k < 5; k++) begin
			push_tx($random(seed));
			push_tx($random(seed));
			pulse(k < 4 ? k : 7, 0);
			lock = 1;
			txq.delete();
			push_tx($random(seed));
			chk_lvl();
			wr(ifm_pkg::addr_flags, 32'h2);
			lock = 0;
			push_tx($random(seed));
			chk_lvl();
		end
		wr(ifm_pkg::addr_txctrl, 32'h22);
		for (int k = 0; k < 2; k++) begin
			pulse(k, 0);
			chk_lvl();
		end
		wr(ifm_pkg::addr_txctrl, 32'h21);
		txq.delete();
		for (int a = 0; a < 2; a++) begin
			wr(ifm_pkg::addr_ctrl, 32'h7 | (a << 3));
			b = $random(seed);
			peer.send_byte(b);
			pulse(4, b);
			repeat (4) @(posedge ref_clk);
			chk("scl_hold", 1, {31'h0, scl_oe});
			peer.idle();
			rd(ifm_pkg::addr_flags, d);
			chk("irxm_flag", 1, {31'h0, d[0]});
			rd(ifm_pkg::addr_fifo, d);
			chk("irxm_data", b, d);
			chk_lvl();
			wr(ifm_pkg::addr_flags, 32'h1);
			n = 0;
			while (scl_oe === 1'b1 && n < 400) begin
				@(posedge ref_clk);
				n++;
			end
			#1;
			chk("scl_release", 0, {31'h0, scl_oe});
			chk("ack_drive", !a, {31'h0, sda_oe});
		end
		@(posedge ref_clk) rx_is_data <= 0;
		peer.send_byte(8'h3c);
		pulse(4, 8'h3c);
		repeat (4) @(posedge ref_clk);
		chk("addr_no_hold", 0, {31'h0, scl_oe});
		rd(ifm_pkg::addr_flags, d);
		chk("addr_no_flag", 0, {31'h0, d[0]});
		@(posedge ref_clk) rx_is_data <= 1;
		wr(ifm_pkg::addr_ctrl, 32'h3);
		@(posedge ref_clk) bus_busy <= 1;
		wr(ifm_pkg::addr_mstr, 32'h1);
		repeat (10) @(posedge ref_clk);
		chk("start_deferred", 0, ns);
		bus_busy <= 0;
		repeat (10) @(posedge ref_clk);
		chk("start_count", 1, ns);
		wr(ifm_pkg::addr_mstr, 32'h6);
		pulse(6, 0);
		repeat (10) @(posedge ref_clk);
		chk("restart_count", 1, nr);
		chk("stop_count", 0, np);
		rd(ifm_pkg::addr_mstr, d);
		chk("restart_stop_bits", 0, {30'h0, d[2:1]});
		wr(ifm_pkg::addr_mstr, 32'h4);
		pulse(6, 0);
		repeat (10) @(posedge ref_clk);
		chk("stop_count", 1, np);
		rd(ifm_pkg::addr_mstr, d);
		chk("start_bit", 0, {31'h0, d[0]});
		wr(ifm_pkg::addr_mstr, 32'h2);
		pulse(7, 0);
		rd(ifm_pkg::addr_mstr, d);
		chk("restart_cancel", 0, {31'h0, d[1]});
		@(posedge ref_clk) bus_busy <= 1;
		wr(ifm_pkg::addr_mstr, 32'h7);
		wr(ifm_pkg::addr_ctrl, 32'h1);
		rd(ifm_pkg::addr_mstr, d);
		chk("mstr_bits", 0, {29'h0, d[2:0]});
		end_of_test();
	end
endmodule // tb_i2c_fifo_irxm_master_control
`default_nettype wire
